// >>> inc/atc_pkg.sv
// ==========================================================================
// shared constants and carriers of the converter control block
package atc_pkg;
  // ========================================================================
  // register offsets (word index on the register port)
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 16;
  localparam logic [5:0]  OFS_CTRL  = 6'h00;
  localparam logic [5:0]  OFS_TSRC  = 6'h01;
  localparam logic [5:0]  OFS_ICTL  = 6'h02;
  localparam logic [5:0]  OFS_START = 6'h03;
  localparam logic [5:0]  OFS_STAT  = 6'h04;
  localparam logic [5:0]  OFS_MASK  = 6'h05;
  localparam logic [5:0]  OFS_CCF   = 6'h06;
  localparam logic [5:0]  OFS_DIEN  = 6'h07;
  localparam logic [5:0]  OFS_CMP   = 6'h08;
  localparam logic [5:0]  OFS_RES0  = 6'h10;
  // ========================================================================
  // field positions
  localparam int unsigned CTRL_RES10 = 0;
  localparam int unsigned CTRL_SCAN  = 1;
  localparam int unsigned CTRL_TEN   = 2;
  localparam int unsigned CTRL_TLVL  = 3;
  localparam int unsigned CTRL_TPOL  = 4;
  localparam int unsigned ICTL_SEQIE = 0;
  localparam int unsigned ICTL_CMPIE = 1;
  localparam int unsigned ST_SEQ     = 0;
  localparam int unsigned ST_CMP     = 1;
  localparam int unsigned ST_OVR     = 2;
  localparam int unsigned ST_BUSY    = 3;
  localparam int unsigned ST_W       = 3;
  localparam int unsigned START_LEN  = 4;
  localparam int unsigned CMP_HI     = 15;
  // ========================================================================
  // reset values and sizes
  localparam logic [3:0]  TSRC_RESET = 4'hb;
  localparam int unsigned NUM_PINS   = 12;
  localparam int unsigned NUM_CHAN   = 8;
  localparam int unsigned RES_W      = 10;
  // ========================================================================
  // timing: sample window, rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SAMPLE_NS     = 40;
  localparam int unsigned SAMPLE_CYC    = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ========================================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } atc_bus_s;
  typedef struct packed {
    logic trig_polarity;
    logic trig_level_select;
    logic trig_external_enable;
    logic scan;
    logic res10;
  } atc_ctrl_s;
endpackage

// >>> core/atc_sync.sv
`timescale 1ns/1ps
// ==========================================================================
// three-stage pin synchroniser; a change counts once stages two and three agree
module atc_sync #(
  parameter int unsigned W = 12
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // stage one feeds stage two only
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a bit only when the two late stages agree
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      q <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
        if (s2_q[i] == s3_q[i])
          q[i] <= s3_q[i];
    end
  end
endmodule // atc_sync

// >>> core/atc_sar.sv
`timescale 1ns/1ps
// ==========================================================================
// successive-approximation engine: sample, then one trial bit per cycle
module atc_sar #(
  parameter int unsigned RW   = atc_pkg::RES_W,
  parameter int unsigned SCYC = atc_pkg::SAMPLE_CYC
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          start,
  input  wire logic          abort,
  input  wire logic          res10,
  input  wire logic          cmp_in,
  output logic               sample,
  output logic      [RW-1:0] dac,
  output logic               busy,
  output logic               done,
  output logic      [RW-1:0] result
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SAMP = 2'b01,
    S_BITS = 2'b10
  } atc_sar_e;

  atc_sar_e     state_q;
  logic [7:0]   cnt_q;
  logic [3:0]   bit_q;
  logic [RW-1:0] one;
  logic [RW-1:0] keep;

  assign one    = {{(RW-1){1'b0}}, 1'b1};
  // trial code with the current bit kept or dropped by the comparator
  assign keep   = cmp_in ? dac : (dac & ~(one << bit_q));
  assign sample = (state_q == S_SAMP);
  assign busy   = (state_q != S_IDLE);

  // binary search; comparator high means sample at or above the trial code
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= S_IDLE;
      cnt_q   <= 8'h00;
      bit_q   <= 4'h0;
      dac     <= '0;
      done    <= 1'b0;
      result  <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
        state_q <= S_IDLE;
      else
      begin
        unique case (state_q)
          S_IDLE:
          begin
            if (start)
            begin
              state_q <= S_SAMP;
              cnt_q   <= 8'(SCYC - 1);
            end
          end
          S_SAMP:
          begin
            if (cnt_q == 8'h00)
            begin
              state_q <= S_BITS;
              bit_q   <= 4'h9;
              dac     <= one << 9;
            end
            else
              cnt_q <= cnt_q - 8'h01;
          end
          S_BITS:
          begin
            // 8-bit stops two trials early so it still spans the full input range
            if (bit_q == (res10 ? 4'h0 : 4'h2))
            begin
              result  <= res10 ? keep : (keep >> 2);
              done    <= 1'b1;
              state_q <= S_IDLE;
            end
            else
            begin
              dac   <= keep | (one << (bit_q - 4'h1));
              bit_q <= bit_q - 4'h1;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // atc_sar

// >>> core/atc_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: resolution is 8 or 10 bits, resolved by binary search.
// RULE2: conversion engine powered only while a sequence runs.
// RULE3: exactly one of eight channels drives the sampler per conversion.
// RULE4: trigger source defaults to pin 11, software may reassign it.
// RULE5: trigger off, scan off: one sequence then stop.
// RULE6: trigger off, scan on: sequences repeat continuously.
// RULE7: edge mode starts one sequence per active edge, polarity selects edge.
// RULE8: level mode converts continuously while trigger active, polarity selects level.
// RULE9: active edge during a running sequence sets the overrun flag.
// RULE10: with trigger enabled, first conversion waits for the trigger.
// RULE11: with trigger enabled, software start writes start nothing.
// RULE12: level mode trigger bounces never set the overrun flag.
// RULE13: level still active at sequence end starts the next sequence immediately.
// RULE14: per-pin enable bits gate digital input buffers, analog path untouched.
// RULE15: reset leaves the converter powered down with reset values.
// RULE16: sequence and compare interrupts each gated by own enable bit.
// RULE17: start register write clears all complete flags, beating a set.
// RULE18: trigger pins are synchronised before edge or level detection.
module atc_ctrl (
  input  wire logic                           clock,
  input  wire logic                           nrst,
  input  wire atc_pkg::atc_bus_s              bus,
  output logic [atc_pkg::DATA_W-1:0]          rdata,
  input  wire logic [atc_pkg::NUM_PINS-1:0]   trig_pins,
  input  wire logic                           cmp_in,
  output logic [2:0]                          ana_chan,
  output logic                                sample,
  output logic                                pwr_up,
  output logic [atc_pkg::RES_W-1:0]           dac_code,
  output logic [atc_pkg::NUM_PINS-1:0]        dig_buf_en,
  output logic                                irq
);
  // ========================================================================
  // sequencer states
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_GO   = 2'b01,
    Q_WAIT = 2'b10
  } atc_seq_e;

  atc_seq_e                        seq_q;
  atc_pkg::atc_ctrl_s              ctrl_q;
  logic [3:0]                      tsrc_q;
  logic [1:0]                      ictl_q;
  logic [atc_pkg::ST_W-1:0]        stat_q;
  logic [atc_pkg::ST_W-1:0]        mask_q;
  logic [atc_pkg::NUM_CHAN-1:0]    ccf_q;
  logic [atc_pkg::NUM_PINS-1:0]    dien_q;
  logic [atc_pkg::DATA_W-1:0]      cmp_q;
  logic [2:0]                      chan_q;
  logic [2:0]                      len_q;
  logic [2:0]                      idx_q;
  logic [atc_pkg::RES_W-1:0]       res_q [atc_pkg::NUM_CHAN];
  logic [atc_pkg::NUM_PINS-1:0]    trig_s;
  logic                            prev_q;
  logic                            sel;
  logic                            lvl_act;
  logic                            edge_evt;
  logic                            trig_go;
  logic                            wr_start;
  logic                            sw_start;
  logic                            idle;
  logic                            sar_busy;
  logic                            sar_done;
  logic [atc_pkg::RES_W-1:0]       sar_res;
  logic                            seq_end;
  logic                            again;
  logic                            cmp_true;
  logic [atc_pkg::ST_W-1:0]        st_set;

  // ========================================================================
  // helpers
  function automatic logic hit(input logic [atc_pkg::ADDR_W-1:0] a, input logic [atc_pkg::ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  // ========================================================================
  // trigger path
  atc_sync #(
    .W (atc_pkg::NUM_PINS)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .pin   (trig_pins),
    .q     (trig_s)  // [RULE18]
  );

  // selected source, out-of-range selects read as low
  assign sel      = (tsrc_q < 4'(atc_pkg::NUM_PINS)) ? trig_s[tsrc_q] : 1'b0;  // [RULE4]
  assign lvl_act  = ctrl_q.trig_polarity ? sel : ~sel;  // [RULE8]
  assign edge_evt = ctrl_q.trig_polarity ? (sel & ~prev_q) : (~sel & prev_q);  // [RULE7]
  assign trig_go  = ctrl_q.trig_external_enable & (ctrl_q.trig_level_select ? lvl_act : edge_evt);  // [RULE10]

  // previous level for the edge detector
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prev_q <= 1'b0;
    else
      prev_q <= sel;
  end

  // ========================================================================
  // sequence control
  assign wr_start = bus.wr & hit(bus.addr, atc_pkg::OFS_START);
  assign sw_start = wr_start & ~ctrl_q.trig_external_enable;  // [RULE11]
  assign idle     = (seq_q == Q_IDLE);
  assign seq_end  = (seq_q == Q_WAIT) & sar_done & (idx_q == len_q);
  // level mode re-arms from the live level, scan from the control bit
  assign again    = ctrl_q.trig_external_enable ? (ctrl_q.trig_level_select & lvl_act) : ctrl_q.scan;  // [RULE6] [RULE13]
  assign ana_chan = chan_q + idx_q;  // [RULE3]
  assign pwr_up   = ~idle;  // [RULE2] [RULE15]

  // software start aborts a running sequence and begins afresh
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      seq_q  <= Q_IDLE;
      idx_q  <= 3'h0;
      chan_q <= 3'h0;
      len_q  <= 3'h0;
    end
    else
    begin
      if (wr_start)
      begin
        chan_q <= bus.wdata[2:0];
        len_q  <= bus.wdata[atc_pkg::START_LEN +: 3];
      end
      if (sw_start)
      begin
        seq_q <= Q_GO;
        idx_q <= 3'h0;
      end
      else
      begin
        unique case (seq_q)
          Q_IDLE:
          begin
            if (trig_go)
            begin
              seq_q <= Q_GO;  // [RULE7] [RULE8]
              idx_q <= 3'h0;
            end
          end
          Q_GO: seq_q <= Q_WAIT;
          Q_WAIT:
          begin
            if (sar_done)
            begin
              if (idx_q != len_q)
              begin
                idx_q <= idx_q + 3'h1;
                seq_q <= Q_GO;
              end
              else if (again)
              begin
                idx_q <= 3'h0;
                seq_q <= Q_GO;
              end
              else
                seq_q <= Q_IDLE;  // [RULE5]
            end
          end
          default: seq_q <= Q_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // conversion engine
  atc_sar u_sar (
    .clock  (clock),
    .nrst   (nrst),
    .start  (seq_q == Q_GO),
    .abort  (sw_start),
    .res10  (ctrl_q.res10),  // [RULE1]
    .cmp_in (cmp_in),
    .sample (sample),
    .dac    (dac_code),
    .busy   (sar_busy),
    .done   (sar_done),
    .result (sar_res)
  );

  assign cmp_true = cmp_q[atc_pkg::CMP_HI] ? (sar_res > cmp_q[atc_pkg::RES_W-1:0])
                                           : (sar_res <= cmp_q[atc_pkg::RES_W-1:0]);

  // result store, one word per conversion slot
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < atc_pkg::NUM_CHAN; i++)
        res_q[i] <= '0;
    end
    else if (seq_q == Q_WAIT && sar_done)
      res_q[idx_q] <= sar_res;
  end

  // ========================================================================
  // control registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= '0;
      tsrc_q <= atc_pkg::TSRC_RESET;  // [RULE4] [RULE15]
      ictl_q <= 2'h0;
      mask_q <= '0;
      dien_q <= '0;
      cmp_q  <= '0;
    end
    else if (bus.wr)
    begin
      if (hit(bus.addr, atc_pkg::OFS_CTRL))
        ctrl_q <= bus.wdata[4:0];
      if (hit(bus.addr, atc_pkg::OFS_TSRC))
        tsrc_q <= bus.wdata[3:0];
      if (hit(bus.addr, atc_pkg::OFS_ICTL))
        ictl_q <= bus.wdata[1:0];
      if (hit(bus.addr, atc_pkg::OFS_MASK))
        mask_q <= bus.wdata[atc_pkg::ST_W-1:0];
      if (hit(bus.addr, atc_pkg::OFS_DIEN))
        dien_q <= bus.wdata[atc_pkg::NUM_PINS-1:0];
      if (hit(bus.addr, atc_pkg::OFS_CMP))
        cmp_q <= bus.wdata;
    end
  end

  // digital buffers follow their enables only; analog pads stay connected
  assign dig_buf_en = dien_q;  // [RULE14]

  // ========================================================================
  // status flags: set wins over a one-written clear
  always_comb
  begin
    st_set                = '0;
    st_set[atc_pkg::ST_SEQ] = seq_end;
    st_set[atc_pkg::ST_CMP] = (seq_q == Q_WAIT) & sar_done & cmp_true;
    // level mode never counts an overrun
    st_set[atc_pkg::ST_OVR] = ctrl_q.trig_external_enable & ~ctrl_q.trig_level_select
                              & edge_evt & ~idle;  // [RULE9] [RULE12]
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      stat_q <= '0;
    else if (bus.wr && hit(bus.addr, atc_pkg::OFS_STAT))
      stat_q <= (stat_q & ~bus.wdata[atc_pkg::ST_W-1:0]) | st_set;
    else
      stat_q <= stat_q | st_set;
  end

  // complete flags: start write clears and beats a set, one-clear loses
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ccf_q <= '0;
    else if (wr_start)
      ccf_q <= '0;  // [RULE17]
    else
    begin
      if (bus.wr && hit(bus.addr, atc_pkg::OFS_CCF))
        ccf_q <= ccf_q & ~bus.wdata[atc_pkg::NUM_CHAN-1:0];
      if (seq_q == Q_WAIT && sar_done)
        ccf_q[idx_q] <= 1'b1;
    end
  end

  // one level output; overrun gated by the mask alone
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q & {1'b1, ictl_q[atc_pkg::ICTL_CMPIE], ictl_q[atc_pkg::ICTL_SEQIE]});  // [RULE16]
  end

  // ========================================================================
  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= '0;
    else
    begin
      rdata <= '0;
      if (bus.rd)
      begin
        if (bus.addr >= atc_pkg::OFS_RES0 && bus.addr < atc_pkg::OFS_RES0 + 6'(atc_pkg::NUM_CHAN))
          rdata <= 16'(res_q[bus.addr[2:0]]);
        else
        begin
          unique case (bus.addr)
            atc_pkg::OFS_CTRL:  rdata <= 16'(ctrl_q);
            atc_pkg::OFS_TSRC:  rdata <= 16'(tsrc_q);
            atc_pkg::OFS_ICTL:  rdata <= 16'(ictl_q);
            atc_pkg::OFS_START: rdata <= 16'({len_q, 1'b0, chan_q});
            atc_pkg::OFS_STAT:  rdata <= 16'({~idle, stat_q});
            atc_pkg::OFS_MASK:  rdata <= 16'(mask_q);
            atc_pkg::OFS_CCF:   rdata <= 16'(ccf_q);
            atc_pkg::OFS_DIEN:  rdata <= 16'(dien_q);
            atc_pkg::OFS_CMP:   rdata <= cmp_q;
            default:            rdata <= 16'h0000;
          endcase
        end
      end
    end
  end

  // ========================================================================
  // checks
  property p_res8;
    @(posedge clock) disable iff (!nrst) sar_done && !ctrl_q.res10 |-> sar_res[9:8] == 2'b00;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result has upper bits"); // [RULE1]
  property p_power;
    @(posedge clock) disable iff (!nrst) sar_busy |-> pwr_up;
  endproperty
  a_power: assert property (p_power) else $error("engine busy while powered down"); // [RULE2]
  property p_chan;
    @(posedge clock) disable iff (!nrst) seq_q == Q_GO |=> sample ##1 (sample && $stable(ana_chan));
  endproperty
  a_chan: assert property (p_chan) else $error("sampling without channel"); // [RULE3]
  property p_oneshot;
    @(posedge clock) disable iff (!nrst)
      seq_end && !ctrl_q.trig_external_enable && !ctrl_q.scan && !wr_start |=> idle;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("single sequence did not stop"); // [RULE5]
  property p_scan;
    @(posedge clock) disable iff (!nrst) seq_end && !ctrl_q.trig_external_enable && ctrl_q.scan |=> seq_q == Q_GO;
  endproperty
  a_scan: assert property (p_scan) else $error("scan did not repeat"); // [RULE6]
  property p_edge;
    @(posedge clock) disable iff (!nrst)
      idle && ctrl_q.trig_external_enable && !ctrl_q.trig_level_select && edge_evt |=> seq_q == Q_GO ##1 seq_q == Q_WAIT;
  endproperty
  a_edge: assert property (p_edge) else $error("edge did not start sequence"); // [RULE7]
  property p_ovr;
    @(posedge clock) disable iff (!nrst)
      ctrl_q.trig_external_enable && !ctrl_q.trig_level_select && edge_evt && !idle |=> stat_q[atc_pkg::ST_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // [RULE9]
  property p_wait;
    @(posedge clock) disable iff (!nrst) idle && ctrl_q.trig_external_enable && !trig_go |=> idle;
  endproperty
  a_wait: assert property (p_wait) else $error("started without trigger"); // [RULE10] [RULE11]
  property p_lvl_ovr;
    @(posedge clock) disable iff (!nrst)
      ctrl_q.trig_external_enable && ctrl_q.trig_level_select |=> !$rose(stat_q[atc_pkg::ST_OVR]);
  endproperty
  a_lvl_ovr: assert property (p_lvl_ovr) else $error("overrun in level mode"); // [RULE12]
  property p_chain;
    @(posedge clock) disable iff (!nrst)
      seq_end && ctrl_q.trig_external_enable && ctrl_q.trig_level_select && lvl_act |=> seq_q == Q_GO;
  endproperty
  a_chain: assert property (p_chain) else $error("level sequence not chained"); // [RULE8] [RULE13]
  property p_ccf;
    @(posedge clock) disable iff (!nrst) wr_start |=> ccf_q == '0;
  endproperty
  a_ccf: assert property (p_ccf) else $error("complete flags survived start write"); // [RULE17]
  property p_irq;
    @(posedge clock) disable iff (!nrst)
      stat_q[atc_pkg::ST_SEQ] && mask_q[atc_pkg::ST_SEQ] && ictl_q[atc_pkg::ICTL_SEQIE] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("sequence interrupt missing"); // [RULE16]
  c_seq: cover property (@(posedge clock) disable iff (!nrst) seq_end);
  c_ovr: cover property (@(posedge clock) disable iff (!nrst) $rose(stat_q[atc_pkg::ST_OVR]));
  c_chain: cover property (@(posedge clock) disable iff (!nrst) seq_end && ctrl_q.trig_level_select ##1 seq_q == Q_GO);
endmodule // atc_ctrl

// >>> sim/atc_ana_model.sv
`timescale 1ns/1ps
// ==========================================================================
// analog path: holds the chosen channel while sampling, compares with trial
module atc_ana_model (
  input  wire logic        clock,
  input  wire logic [2:0]  ana_chan,
  input  wire logic        sample,
  input  wire logic [9:0]  dac_code,
  input  wire logic [79:0] vin,
  output logic             cmp_in
);
  logic [9:0] held_q;
  // only the selected channel reaches the hold node
  always @(posedge clock)
    if (sample)
      held_q <= vin[ana_chan*10 +: 10];
  // trial code at or below the held level answers high
  assign cmp_in = (held_q >= dac_code);
endmodule // atc_ana_model

// >>> sim/atc_ctrl_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// converter control bench
module atc_ctrl_tb;
  logic              clock;
  logic              nrst;
  atc_pkg::atc_bus_s bus;
  logic [15:0]       rdata;
  logic [15:0]       rv;
  logic [11:0]       trig_pins;
  logic [11:0]       dig_buf_en;
  logic [11:0]       tm;
  logic [9:0]        dac_code;
  logic [79:0]       vin;
  logic [2:0]        ana_chan;
  logic              cmp_in;
  logic              sample;
  logic              pwr_up;
  logic              irq;
  int                err_total;
  int                samples_checked;
  int                cycles;
  int                c0;

  atc_ctrl uut (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata), .trig_pins(trig_pins), .cmp_in(cmp_in),
    .ana_chan(ana_chan), .sample(sample), .pwr_up(pwr_up), .dac_code(dac_code), .dig_buf_en(dig_buf_en), .irq(irq));
  atc_ana_model ana (.clock(clock), .ana_chan(ana_chan), .sample(sample), .dac_code(dac_code), .vin(vin),
    .cmp_in(cmp_in));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 rv = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pin(input logic [11:0] v);
    @(posedge clock);
    trig_pins <= v;
  endtask

  // bounded poll of busy; the cycle ceiling backs it up
  task automatic wait_idle;
    int n;
    n = 0;
    rd(atc_pkg::OFS_STAT);
    while (rv[atc_pkg::ST_BUSY] !== 1'b0 && n < 300)
    begin
      rd(atc_pkg::OFS_STAT);
      n++;
    end
  endtask

  // each result against the voltage of its channel
  task automatic chk_res(input int len, input int ch);
    for (int i = 0; i < len; i++)
    begin
      rd(atc_pkg::OFS_RES0 + 6'(i));
      chk(rv, {6'h00, vin[((ch + i) % 8) * 10 +: 10]});
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ceiling far above the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    nrst = 1'b0;
    bus = '0;
    trig_pins = 12'h000;
    vin = '0;
    void'($urandom(50384));
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd(atc_pkg::OFS_TSRC);
    chk(rv, 16'h000b);
    rd(atc_pkg::OFS_STAT);
    chk(rv, 16'h0000);
    rd(6'h3f);
    chk(rv, 16'h0000);
    chk({15'h0, pwr_up | irq}, 16'h0000);
    $display("reset test done");
    // software sequence of three, random channels, both interrupts
    wr(atc_pkg::OFS_CTRL, 16'h0001);
    for (int i = 0; i < 8; i++)
      vin[i*10 +: 10] <= 10'($urandom) | 10'h001;
    c0 = $urandom_range(7);
    wr(atc_pkg::OFS_CMP, 16'h8000);
    wr(atc_pkg::OFS_ICTL, 16'h0003);
    wr(atc_pkg::OFS_MASK, 16'h0003);
    wr(atc_pkg::OFS_START, 16'h0020 | 16'(c0));
    settle(2);
    chk({15'h0, pwr_up}, 16'h0001);
    wait_idle();
    chk_res(3, c0);
    rd(atc_pkg::OFS_STAT);
    chk(rv, 16'h0003);
    rd(atc_pkg::OFS_CCF);
    chk(rv, 16'h0007);
    chk({15'h0, irq}, 16'h0001);
    wr(atc_pkg::OFS_MASK, 16'h0002);
    wr(atc_pkg::OFS_STAT, 16'h0002);
    settle(2);
    chk({15'h0, irq | pwr_up}, 16'h0000);
    c0 = $urandom;
    wr(atc_pkg::OFS_DIEN, 16'(c0) & 16'h0fff);
    settle(2);
    chk({4'h0, dig_buf_en}, 16'(c0) & 16'h0fff);
    // 8-bit keeps the full input span with coarser steps
    wr(atc_pkg::OFS_CTRL, 16'h0000);
    wr(atc_pkg::OFS_START, 16'(c0) & 16'h0007);
    wait_idle();
    rd(atc_pkg::OFS_RES0);
    chk(rv, {8'h00, vin[(c0 & 7) * 10 + 2 +: 8]});
    $display("software test done");
    // edge triggers, falling on pad 3 then rising on pad 11
    for (int p = 0; p < 2; p++)
    begin
      tm = p ? 12'h800 : 12'h008;
      pin(p ? 12'h000 : 12'hfff);
      settle(5);
      wr(atc_pkg::OFS_TSRC, p ? 16'h000b : 16'h0003);
      wr(atc_pkg::OFS_CTRL, 16'(p * 16 + 5));
      wr(atc_pkg::OFS_START, 16'h0010);
      settle(10);
      chk({15'h0, pwr_up}, 16'h0000);
      rd(atc_pkg::OFS_CCF);
      chk(rv, 16'h0000);
      pin(trig_pins ^ tm);
      settle(8);
      chk({15'h0, pwr_up}, 16'h0001);
      pin(trig_pins ^ tm);
      settle(3);
      pin(trig_pins ^ tm);
      wait_idle();
      chk_res(2, 0);
      rd(atc_pkg::OFS_STAT);
      chk(rv & 16'h0005, 16'h0005);
      wr(atc_pkg::OFS_STAT, 16'h0007);
      wr(atc_pkg::OFS_CTRL, 16'h0000);
    end
    $display("edge test done");
    // level trigger held high with a short bounce; let the pad settle low first
    pin(12'h000);
    settle(5);
    wr(atc_pkg::OFS_CTRL, 16'h001d);
    wr(atc_pkg::OFS_START, 16'h0010);
    settle(10);
    chk({15'h0, pwr_up}, 16'h0000);
    pin(12'h800);
    settle(40);
    pin(12'h000);
    settle(2);
    pin(12'h800);
    settle(40);
    rd(atc_pkg::OFS_STAT);
    chk(rv & 16'h000d, 16'h0009);
    pin(12'h000);
    wait_idle();
    settle(2);
    chk({15'h0, pwr_up}, 16'h0000);
    $display("level test done");
    // continuous software sequences
    wr(atc_pkg::OFS_STAT, 16'h0007);
    wr(atc_pkg::OFS_CTRL, 16'h0003);
    wr(atc_pkg::OFS_START, 16'h0000);
    settle(50);
    rd(atc_pkg::OFS_STAT);
    chk(rv & 16'h0009, 16'h0009);
    wr(atc_pkg::OFS_CTRL, 16'h0001);
    wait_idle();
    settle(2);
    chk({15'h0, pwr_up}, 16'h0000);
    $display("scan test done");
    conclude();
  end
endmodule // atc_ctrl_tb
